// *** include/mhcp_pkg.sv ***
// Shared constants of the motion host command port: register map over AXI4-Lite,
// command encodings, status fields and internal processing delays.
// Assumes a single 50 MHz clock and a synchronous active-high reset.
package mhcp_pkg;

	// ************************************************************
	// Register byte addresses on the AXI4-Lite bus
	// ************************************************************
	localparam logic [7:0] ADDR_COMMAND_BUFFER = 8'h00;
	localparam logic [7:0] ADDR_WRITE_BUFFER   = 8'h04;
	localparam logic [7:0] ADDR_READ_BYTE_HI   = 8'h08;
	localparam logic [7:0] ADDR_READ_BYTE_MID  = 8'h0C;
	localparam logic [7:0] ADDR_READ_BYTE_LO   = 8'h10;
	localparam logic [7:0] ADDR_STATUS         = 8'h14;
	localparam logic [7:0] ADDR_MODE           = 8'h18;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int        STAT_BUSY_BIT    = 0;
	localparam int        STAT_RUN_BIT     = 1;
	localparam int        STAT_HOLD_BIT    = 2;
	localparam int        STAT_IRQ_BIT     = 3;
	localparam int        STAT_SKIP_BIT    = 4;
	localparam int        STAT_BCNT_LSB    = 5;
	localparam int        MODE_COMPAT_BIT  = 0;
	localparam int        MODE_SELECT_BIT  = 1;
	localparam logic [1:0] MODE_RESET      = 2'h0;
	localparam logic [5:0] OUT_MODE_RESET  = 6'h00;
	localparam logic [23:0] REG_RESET      = 24'h000000;

	// ************************************************************
	// Command encoding: type in bits 7..6
	// ************************************************************
	localparam logic [1:0] CMD_TYPE_CONTROL  = 2'h0;
	localparam logic [1:0] CMD_TYPE_START    = 2'h1;
	localparam logic [1:0] CMD_TYPE_OUTMODE  = 2'h2;
	localparam logic [1:0] CMD_TYPE_REGSEL   = 2'h3;
	localparam int         CMD_GO_BIT        = 4;
	localparam int         CMD_HOLD_BIT      = 3;
	localparam int         CMD_STOP_BIT      = 0;

	// ************************************************************
	// Internal processing delays in clock cycles
	// ************************************************************
	localparam logic [1:0] REG_PROC_CYCLES = 2'h3;
	localparam logic [1:0] CMD_PROC_CYCLES = 2'h2;

	// ************************************************************
	// AXI responses and pending operation kinds
	// ************************************************************
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		OP_NONE   = 2'b00,
		OP_CMD    = 2'b01,
		OP_SELECT = 2'b10,
		OP_COMMIT = 2'b11
	} mhcp_op_t;

	typedef enum logic [1:0] {
		MOT_IDLE = 2'b00,
		MOT_HOLD = 2'b01,
		MOT_RUN  = 2'b10
	} mhcp_motion_t;

endpackage : mhcp_pkg

// *** rtl/mhcp_port.sv ***
// Host command port of a pulse-motor controller, reached over AXI4-Lite.
// Holds the command buffer, the byte-wise register write buffer, the read buffer
// and a small hold/run motion state. Assumes inputs synchronous to clock_i.

// ************************************************************
// Top module
// ************************************************************
// Notes on behaviour
// - The first data byte after selection fills bits 23 to 16 of the register value.
// - The second data byte fills bits 15 to 8 of the register value.
// - The third data byte fills bits 7 to 0 and completes the register value.
// - The wait request stays active long enough to enforce the processing delays itself.
// - The selected register value sits in the read buffer, readable byte by byte in any order.
// - A start mode, control or output mode command changes internal state two cycles later.
// - One start command starts the motor, even directly after a stop, unless it follows a hold start abort outside legacy mode.
// - A dummy command with bit 4 cleared before the start command changes nothing.
// - In legacy mode a stop or limit during a hold start, before the go trigger, raises irq.
// - In that legacy case every later start command is accepted.
// - Outside legacy mode the hold start abort keeps the old behaviour.
module mhcp_port #(
	parameter int NUM_REGS = 8
) (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	input  wire logic        stop_input_n_i,
	input  wire logic        limit_switch_input_n_i,
	input  wire logic        go_trigger_input_n_i,
	output logic             wait_request_n_o,
	output logic             interrupt_o,
	output logic             motor_run_o,
	output logic [5:0]       output_mode_o
);

	localparam int IDX_W = (NUM_REGS > 1) ? $clog2(NUM_REGS) : 1;

	// ************************************************************
	// Address decode helper, used by both bus channels
	// ************************************************************
	function automatic logic addr_mapped(input logic [7:0] addr);
		addr_mapped = (addr == mhcp_pkg::ADDR_COMMAND_BUFFER) ||
			(addr == mhcp_pkg::ADDR_WRITE_BUFFER) ||
			(addr == mhcp_pkg::ADDR_READ_BYTE_HI) ||
			(addr == mhcp_pkg::ADDR_READ_BYTE_MID) ||
			(addr == mhcp_pkg::ADDR_READ_BYTE_LO) ||
			(addr == mhcp_pkg::ADDR_STATUS) ||
			(addr == mhcp_pkg::ADDR_MODE);
	endfunction : addr_mapped

	// ************************************************************
	// State
	// ************************************************************
	logic [7:0]           aw_addr_reg;
	logic                 aw_full_reg;
	logic [7:0]           w_data_reg;
	logic                 w_lane0_reg;
	logic                 w_full_reg;
	logic                 bvalid_reg;
	logic [1:0]           bresp_reg;
	logic                 rvalid_reg;
	logic [1:0]           rresp_reg;
	logic [31:0]          rdata_reg;
	logic [1:0]           busy_cnt_reg;
	mhcp_pkg::mhcp_op_t   op_reg;
	logic [7:0]           op_cmd_reg;
	logic [IDX_W-1:0]     sel_idx_reg;
	logic [1:0]           byte_cnt_reg;
	logic [23:0]          wbuf_reg;
	logic [23:0]          rbuf_reg;
	logic [23:0]          regs_reg [NUM_REGS];
	logic [1:0]           mode_reg;
	logic [5:0]           out_mode_reg;
	mhcp_pkg::mhcp_motion_t motion_reg;
	logic                 irq_reg;
	logic                 skip_start_reg;
	logic                 wr_fire;
	logic                 rd_fire;
	logic                 busy;
	logic                 legacy;
	logic                 apply;
	logic                 abort_hold;
	logic                 cmd_write;
	logic [31:0]          status_word;

	// ************************************************************
	// Handshake and decode terms
	// ************************************************************
	// Busy stalls both channels, so the bus itself enforces the processing delay.
	assign busy          = (busy_cnt_reg != 2'h0);
	assign wr_fire       = aw_full_reg && w_full_reg && !bvalid_reg && !busy;
	assign rd_fire       = s_axi_arvalid_i && !rvalid_reg && !busy;
	assign cmd_write     = wr_fire && w_lane0_reg &&
		(aw_addr_reg == mhcp_pkg::ADDR_COMMAND_BUFFER);
	assign apply         = (busy_cnt_reg == 2'h1);
	assign legacy        = mode_reg[mhcp_pkg::MODE_COMPAT_BIT] &&
		mode_reg[mhcp_pkg::MODE_SELECT_BIT];
	assign abort_hold    = (motion_reg == mhcp_pkg::MOT_HOLD) &&
		(!stop_input_n_i || !limit_switch_input_n_i);

	assign s_axi_awready_o = !aw_full_reg;
	assign s_axi_wready_o  = !w_full_reg;
	assign s_axi_arready_o = !rvalid_reg && !busy;
	assign s_axi_bvalid_o  = bvalid_reg;
	assign s_axi_bresp_o   = bresp_reg;
	assign s_axi_rvalid_o  = rvalid_reg;
	assign s_axi_rresp_o   = rresp_reg;
	assign s_axi_rdata_o   = rdata_reg;
	assign wait_request_n_o = !busy;
	assign interrupt_o     = irq_reg;
	assign motor_run_o     = (motion_reg == mhcp_pkg::MOT_RUN);
	assign output_mode_o   = out_mode_reg;

	always_comb begin
		status_word = 32'h00000000;
		status_word[mhcp_pkg::STAT_BUSY_BIT] = busy;
		status_word[mhcp_pkg::STAT_RUN_BIT]  = (motion_reg == mhcp_pkg::MOT_RUN);
		status_word[mhcp_pkg::STAT_HOLD_BIT] = (motion_reg == mhcp_pkg::MOT_HOLD);
		status_word[mhcp_pkg::STAT_IRQ_BIT]  = irq_reg;
		status_word[mhcp_pkg::STAT_SKIP_BIT] = skip_start_reg;
		status_word[mhcp_pkg::STAT_BCNT_LSB +: 2] = byte_cnt_reg;
	end

	// ************************************************************
	// Write channels: address and data are held apart and may come in any order
	// ************************************************************
	// Each holding slot frees only when the pair executes.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			aw_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_full_reg  <= 1'b0;
			w_data_reg  <= 8'h00;
			w_lane0_reg <= 1'b0;
		end else begin
			if (s_axi_awvalid_i && !aw_full_reg) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr_i;
			end else if (wr_fire) begin
				aw_full_reg <= 1'b0;
			end
			if (s_axi_wvalid_i && !w_full_reg) begin
				w_full_reg  <= 1'b1;
				w_data_reg  <= s_axi_wdata_i[7:0];
				w_lane0_reg <= s_axi_wstrb_i[0];
			end else if (wr_fire) begin
				w_full_reg <= 1'b0;
			end
		end
	end

	// Write response follows the executed pair; unmapped addresses answer SLVERR.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= mhcp_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= addr_mapped(aw_addr_reg) ? mhcp_pkg::RESP_OKAY : mhcp_pkg::RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			bvalid_reg <= 1'b0;
		end
	end

	// ************************************************************
	// Read channel
	// ************************************************************
	// The read buffer is byte addressable, so the host reads bytes in any order.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= mhcp_pkg::RESP_OKAY;
			rdata_reg  <= 32'h00000000;
		end else if (rd_fire) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= addr_mapped(s_axi_araddr_i) ? mhcp_pkg::RESP_OKAY : mhcp_pkg::RESP_SLVERR;
			unique case (s_axi_araddr_i)
				mhcp_pkg::ADDR_READ_BYTE_HI:  rdata_reg <= {24'h000000, rbuf_reg[23:16]};
				mhcp_pkg::ADDR_READ_BYTE_MID: rdata_reg <= {24'h000000, rbuf_reg[15:8]};
				mhcp_pkg::ADDR_READ_BYTE_LO:  rdata_reg <= {24'h000000, rbuf_reg[7:0]};
				mhcp_pkg::ADDR_STATUS:        rdata_reg <= status_word;
				mhcp_pkg::ADDR_MODE:          rdata_reg <= {30'h00000000, mode_reg};
				default:                      rdata_reg <= 32'h00000000;
			endcase
		end else if (s_axi_rready_i) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ************************************************************
	// Processing timer and pending operation
	// ************************************************************
	// A command or write buffer write loads the timer; the pending operation lands when it reaches one.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			busy_cnt_reg <= 2'h0;
			op_reg       <= mhcp_pkg::OP_NONE;
			op_cmd_reg   <= 8'h00;
		end else if (cmd_write) begin
			op_cmd_reg <= w_data_reg;
			if (w_data_reg[7:6] == mhcp_pkg::CMD_TYPE_REGSEL) begin
				busy_cnt_reg <= mhcp_pkg::REG_PROC_CYCLES;
				op_reg       <= mhcp_pkg::OP_SELECT;
			end else begin
				busy_cnt_reg <= mhcp_pkg::CMD_PROC_CYCLES;
				op_reg       <= mhcp_pkg::OP_CMD;
			end
		end else if (wr_fire && w_lane0_reg && aw_addr_reg == mhcp_pkg::ADDR_WRITE_BUFFER) begin
			busy_cnt_reg <= mhcp_pkg::REG_PROC_CYCLES;
			op_reg       <= (byte_cnt_reg == 2'h2) ? mhcp_pkg::OP_COMMIT : mhcp_pkg::OP_NONE;
		end else if (busy) begin
			busy_cnt_reg <= busy_cnt_reg - 2'h1;
			if (apply) begin
				op_reg <= mhcp_pkg::OP_NONE;
			end
		end
	end

	// ************************************************************
	// Register selection, write buffer and read buffer
	// ************************************************************
	// Bytes before any selection still land in order; software must select first.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			sel_idx_reg  <= '0;
			byte_cnt_reg <= 2'h0;
			wbuf_reg     <= mhcp_pkg::REG_RESET;
		end else if (cmd_write && w_data_reg[7:6] == mhcp_pkg::CMD_TYPE_REGSEL) begin
			sel_idx_reg  <= w_data_reg[IDX_W-1:0];
			byte_cnt_reg <= 2'h0;
		end else if (wr_fire && w_lane0_reg && aw_addr_reg == mhcp_pkg::ADDR_WRITE_BUFFER) begin
			unique case (byte_cnt_reg)
				2'h0: wbuf_reg[23:16] <= w_data_reg;
				2'h1: wbuf_reg[15:8]  <= w_data_reg;
				default: wbuf_reg[7:0] <= w_data_reg;
			endcase
			byte_cnt_reg <= (byte_cnt_reg == 2'h2) ? 2'h0 : byte_cnt_reg + 2'h1;
		end
	end

	// The register array and read buffer change only as the processing delay ends.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rbuf_reg <= mhcp_pkg::REG_RESET;
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_reg[i] <= mhcp_pkg::REG_RESET;
			end
		end else if (apply && op_reg == mhcp_pkg::OP_COMMIT) begin
			regs_reg[sel_idx_reg] <= wbuf_reg;
			rbuf_reg              <= wbuf_reg;
		end else if (apply && op_reg == mhcp_pkg::OP_SELECT) begin
			rbuf_reg <= regs_reg[sel_idx_reg];
		end
	end

	// ************************************************************
	// Mode register and output mode
	// ************************************************************
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			mode_reg <= mhcp_pkg::MODE_RESET;
		end else if (wr_fire && w_lane0_reg && aw_addr_reg == mhcp_pkg::ADDR_MODE) begin
			mode_reg <= w_data_reg[1:0];
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			out_mode_reg <= mhcp_pkg::OUT_MODE_RESET;
		end else if (apply && op_reg == mhcp_pkg::OP_CMD &&
				op_cmd_reg[7:6] == mhcp_pkg::CMD_TYPE_OUTMODE) begin
			out_mode_reg <= op_cmd_reg[5:0];
		end
	end

	// ************************************************************
	// Motion state
	// ************************************************************
	// Commands act at the second edge after the write; a start is swallowed only after a
	// hold start abort outside legacy mode, and a dummy with the go bit cleared leaves the state alone.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			motion_reg <= mhcp_pkg::MOT_IDLE;
		end else if (apply && op_reg == mhcp_pkg::OP_CMD &&
				op_cmd_reg[7:6] == mhcp_pkg::CMD_TYPE_CONTROL &&
				op_cmd_reg[mhcp_pkg::CMD_STOP_BIT]) begin
			motion_reg <= mhcp_pkg::MOT_IDLE;
		end else if (apply && op_reg == mhcp_pkg::OP_CMD &&
				op_cmd_reg[7:6] == mhcp_pkg::CMD_TYPE_START &&
				op_cmd_reg[mhcp_pkg::CMD_GO_BIT] && !skip_start_reg) begin
			motion_reg <= op_cmd_reg[mhcp_pkg::CMD_HOLD_BIT] ?
				mhcp_pkg::MOT_HOLD : mhcp_pkg::MOT_RUN;
		end else if (abort_hold) begin
			motion_reg <= mhcp_pkg::MOT_IDLE;
		end else if (motion_reg == mhcp_pkg::MOT_HOLD && !go_trigger_input_n_i) begin
			motion_reg <= mhcp_pkg::MOT_RUN;
		end else if (motion_reg == mhcp_pkg::MOT_RUN &&
				(!stop_input_n_i || !limit_switch_input_n_i)) begin
			motion_reg <= mhcp_pkg::MOT_IDLE;
		end
	end

	// ************************************************************
	// Hold start abort: interrupt in legacy mode, old start swallowing otherwise
	// ************************************************************
	// A new command write clears the interrupt, but an abort in the same cycle wins.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			irq_reg <= 1'b0;
		end else if (abort_hold && legacy) begin
			irq_reg <= 1'b1;
		end else if (cmd_write) begin
			irq_reg <= 1'b0;
		end
	end

	// Outside legacy mode the first start after an abort is consumed without effect.
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			skip_start_reg <= 1'b0;
		end else if (abort_hold && !legacy) begin
			skip_start_reg <= 1'b1;
		end else if (abort_hold && legacy) begin
			skip_start_reg <= 1'b0;
		end else if (apply && op_reg == mhcp_pkg::OP_CMD &&
				op_cmd_reg[7:6] == mhcp_pkg::CMD_TYPE_START &&
				op_cmd_reg[mhcp_pkg::CMD_GO_BIT]) begin
			skip_start_reg <= 1'b0;
		end
	end

endmodule : mhcp_port

// *** dv/mhcp_port_monitor.sv ***
// Checker of the motion host command port, bound to every instance of the port.
// Assumes one clock domain and a synchronous active-high reset.
module mhcp_port_monitor (
	input wire logic        clock_i,
	input wire logic        rst_i,
	input wire logic [7:0]  s_axi_araddr_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0]  s_axi_rresp_o,
	input wire logic        stop_input_n_i,
	input wire logic        limit_switch_input_n_i,
	input wire logic        go_trigger_input_n_i,
	input wire logic        wait_request_n_o,
	input wire logic        interrupt_o,
	input wire logic        motor_run_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************
	// Port properties
	// ************************************************************
	// All checks share the one clock; reset silences them.
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	property p_wait_width;
		$fell(wait_request_n_o) |=> !wait_request_n_o ##[1:2] wait_request_n_o;
	endproperty
	a_wait_width: assert property (p_wait_width) else $error("wait width wrong");

	property p_no_read_busy;
		!wait_request_n_o |-> !s_axi_arready_o;
	endproperty
	a_no_read_busy: assert property (p_no_read_busy) else $error("read taken busy");

	property p_no_write_busy;
		$rose(s_axi_bvalid_o) |-> $past(wait_request_n_o);
	endproperty
	a_no_write_busy: assert property (p_no_write_busy) else $error("write ran busy");

	property p_bresp_hold;
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
	endproperty
	a_bresp_hold: assert property (p_bresp_hold) else $error("write answer dropped");

	property p_rdata_hold;
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read answer dropped");

	property p_unmapped_read;
		s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i > 8'h18
			|=> s_axi_rvalid_o && s_axi_rresp_o == mhcp_pkg::RESP_SLVERR;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("bad read answer");

	property p_irq_cause;
		$rose(interrupt_o) |-> !$past(stop_input_n_i) || !$past(limit_switch_input_n_i);
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without abort");

	// A run starts only at the end of command processing or on the go trigger.
	property p_run_cause;
		$rose(motor_run_o) |-> $rose(wait_request_n_o) || !$past(go_trigger_input_n_i);
	endproperty
	a_run_cause: assert property (p_run_cause) else $error("run start off time");

	property p_reset;
		$fell(rst_i) |-> wait_request_n_o && !interrupt_o && !motor_run_o && !s_axi_bvalid_o;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule : mhcp_port_monitor

bind mhcp_port mhcp_port_monitor mhcp_port_monitor_inst (.*);

// *** dv/mhcp_switch_model.sv ***
// Stop, limit and go switch lines that face the motion port.
// Assumes the bench asks for pulses; lines idle high as open switches with pull-ups.
module mhcp_switch_model (
	input  wire logic clock_i,
	output logic      stop_n_o,
	output logic      limit_n_o,
	output logic      go_n_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		stop_n_o = 1'b1;
		limit_n_o = 1'b1;
		go_n_o = 1'b1;
	end

	// One-cycle closure: 0 stop, 1 limit, 2 go; released back to the pull-up level.
	task automatic pulse(input int which);
		@(posedge clock_i);
		stop_n_o <= (which != 0);
		limit_n_o <= (which != 1);
		go_n_o <= (which != 2);
		@(posedge clock_i);
		stop_n_o <= 1'b1;
		limit_n_o <= 1'b1;
		go_n_o <= 1'b1;
	endtask : pulse
endmodule : mhcp_switch_model

// *** dv/tb.sv ***
// Self-checking bench of the motion host command port over AXI4-Lite.
// Assumes the checker is bound by its own file and switches come from the model.
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clock_i, rst_i, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp, r;
	logic        awready, wready, bvalid, arready, rvalid, stop_n, limit_n, go_n;
	logic        wait_n, irq, run;
	logic [5:0]  out_mode;
	logic [31:0] d;
	int          error_cnt, compares;

	mhcp_port mhcp_port_inst (.clock_i(clock_i), .rst_i(rst_i),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .stop_input_n_i(stop_n),
		.limit_switch_input_n_i(limit_n), .go_trigger_input_n_i(go_n),
		.wait_request_n_o(wait_n), .interrupt_o(irq), .motor_run_o(run),
		.output_mode_o(out_mode));

	mhcp_switch_model mhcp_switch_model_inst (.clock_i(clock_i), .stop_n_o(stop_n),
		.limit_n_o(limit_n), .go_n_o(go_n));

	// 50 MHz clock.
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	// ************************************************************
	// Bus tasks and comparison
	// ************************************************************
	// Ready stands with the request, so the answer is taken at the edge it is first seen.
	task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rs);
		@(posedge clock_i);
		awaddr <= a;
		wdata <= {24'h000000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock_i);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge clock_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock_i);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s: expected %0h, seen %0h", what, exp, seen);
		end
	endtask : chk

	task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string what);
		rd(a, d, r);
		chk(d, {24'h000000, e}, what);
		chk({30'h0, r}, {30'h0, mhcp_pkg::RESP_OKAY}, what);
	endtask : rchk

	// Command write; except for a register select the answer comes one edge before the apply edge, so wait that out.
	task automatic cmdw(input logic [7:0] v);
		wr(mhcp_pkg::ADDR_COMMAND_BUFFER, v, r);
		chk({30'h0, r}, {30'h0, mhcp_pkg::RESP_OKAY}, "command answer");
		@(posedge clock_i);
		#1;
	endtask : cmdw

	task automatic complete_run;
		$display("compares %0d, error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run

	// Tests need under a thousand cycles; five thousand means a hang.
	initial begin
		#100000;
		error_cnt++;
		complete_run();
	end

	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata} = 48'h000000000000;
		error_cnt = 0;
		compares = 0;
		rst_i = 1'b1;
		repeat (5) @(posedge clock_i);
		rst_i <= 1'b0;
		rchk(mhcp_pkg::ADDR_STATUS, 8'h00, "status");
		rchk(mhcp_pkg::ADDR_MODE, 8'h00, "mode");
		$display("test reset done");
		// Bytes are read back out of order after a three-byte load.
		cmdw(8'hC5);
		wr(mhcp_pkg::ADDR_WRITE_BUFFER, 8'hA1, r);
		wr(mhcp_pkg::ADDR_WRITE_BUFFER, 8'hB2, r);
		wr(mhcp_pkg::ADDR_WRITE_BUFFER, 8'hC3, r);
		rchk(mhcp_pkg::ADDR_READ_BYTE_LO, 8'hC3, "low byte");
		rchk(mhcp_pkg::ADDR_READ_BYTE_HI, 8'hA1, "high byte");
		cmdw(8'hC2);
		rchk(mhcp_pkg::ADDR_READ_BYTE_HI, 8'h00, "other reg");
		cmdw(8'hC5);
		rchk(mhcp_pkg::ADDR_READ_BYTE_MID, 8'hB2, "mid byte");
		$display("test register done");
		// Looked at just after the edge before the apply edge, then just after it.
		wr(mhcp_pkg::ADDR_COMMAND_BUFFER, 8'hAA, r);
		#1;
		chk({26'h0, out_mode}, 32'h0, "mode early");
		@(posedge clock_i);
		#1;
		chk({26'h0, out_mode}, 32'h2A, "mode applied");
		$display("test output mode done");
		cmdw(8'h50);
		chk(run, 1, "start");
		cmdw(8'h01);
		chk(run, 0, "stop");
		cmdw(8'h50);
		chk(run, 1, "restart");
		cmdw(8'h01);
		cmdw(8'h40);
		chk(run, 0, "dummy");
		cmdw(8'h50);
		chk(run, 1, "after dummy");
		cmdw(8'h01);
		$display("test start done");
		// Two legacy aborts, then one with the select bit clear using the limit.
		for (int k = 0; k < 3; k++) begin
			wr(mhcp_pkg::ADDR_MODE, (k == 2) ? 8'h01 : 8'h03, r);
			cmdw(8'h58);
			mhcp_switch_model_inst.pulse((k == 2) ? 1 : 0);
			repeat (2) @(posedge clock_i);
			#1;
			chk(irq, k < 2, "abort irq");
			cmdw(8'h50);
			chk(run, k < 2, "start after abort");
			if (k == 2) begin
				cmdw(8'h50);
				chk(run, 1, "second start");
			end
			cmdw(8'h01);
		end
		cmdw(8'h58);
		rchk(mhcp_pkg::ADDR_STATUS, 8'h04, "hold state");
		mhcp_switch_model_inst.pulse(2);
		repeat (2) @(posedge clock_i);
		#1;
		chk(run, 1, "go trigger");
		cmdw(8'h01);
		$display("test hold done");
		wr(8'h20, 8'h00, r);
		chk({30'h0, r}, {30'h0, mhcp_pkg::RESP_SLVERR}, "bad write");
		rd(8'h3C, d, r);
		chk({30'h0, r}, {30'h0, mhcp_pkg::RESP_SLVERR}, "bad read");
		$display("test unmapped done");
		complete_run();
	end
endmodule : tb
